// ---- src/pclm_top.sv ----
// pulse counter and length meter of a motor drive, with a wishbone register file.
// assumes classic wishbone master on clk; terminal pins are asynchronous.
`timescale 1ns/1ps
module pclm_top (
	input wire logic clk, // 20 MHz system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic wb_cyc_i, // wishbone cycle
	input wire logic wb_stb_i, // wishbone strobe
	input wire logic wb_we_i, // wishbone write enable
	input wire logic [7:0] wb_adr_i, // wishbone byte address
	input wire logic [3:0] wb_sel_i, // wishbone byte enables
	input wire logic [31:0] wb_dat_i, // wishbone write data
	output logic [31:0] wb_dat_o, // wishbone read data
	output logic wb_ack_o, // wishbone acknowledge
	input wire logic digital_input_one, // input terminal one
	input wire logic digital_input_two, // input terminal two
	input wire logic fast_pulse_input, // dedicated fast pulse terminal
	output logic digital_output_one, // output terminal one
	output logic digital_output_two // output terminal two
);
	// ----------------------------------------------------------------
	// input terminals
	// ----------------------------------------------------------------
	logic [pclm_pkg::NUM_INPUTS-1:0] pins;
	logic [pclm_pkg::NUM_INPUTS-1:0] pin_level;
	logic [pclm_pkg::NUM_INPUTS-1:0] pin_rise;
	logic [pclm_pkg::NUM_INPUTS-1:0][7:0] pin_func;
	pclm_pkg::pclm_cfg_t cfg_reg;
	pclm_pkg::pclm_cfg_t cfg_next;

	assign pins = {fast_pulse_input, digital_input_two, digital_input_one};
	assign pin_func = {cfg_reg.fast_input_function_select, cfg_reg.input_two_function_select,
		cfg_reg.input_one_function_select};

	genvar gi;
	generate
		for (gi = 0; gi < pclm_pkg::NUM_INPUTS; gi++) begin : g_term
			pclm_term_sync u_sync (
				.clk(clk),
				.rst(rst),
				.pin(pins[gi]),
				.level(pin_level[gi]),
				.rise(pin_rise[gi])
			);
		end
	endgenerate

	logic cnt_pulse;
	logic cnt_clr;
	logic len_pulse;
	logic len_reset_level;
	logic len_clr;

	always_comb begin
		cnt_pulse = 1'b0;
		cnt_clr = 1'b0;
		len_pulse = 1'b0;
		len_reset_level = 1'b0;
		for (int i = 0; i < pclm_pkg::NUM_INPUTS; i++) begin
			cnt_pulse = cnt_pulse | (pin_rise[i] && pin_func[i] == pclm_pkg::FN_COUNTER_INPUT);
			cnt_clr = cnt_clr | (pin_level[i] && pin_func[i] == pclm_pkg::FN_COUNTER_RESET);
			len_pulse = len_pulse | (pin_rise[i] && pin_func[i] == pclm_pkg::FN_LENGTH_COUNT_INPUT);
			len_reset_level = len_reset_level | (pin_level[i] && pin_func[i] == pclm_pkg::FN_LENGTH_RESET);
		end
		len_clr = len_reset_level & cfg_reg.fixed_length_run;
	end

	// ----------------------------------------------------------------
	// pulse counter
	// ----------------------------------------------------------------
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;
	pclm_pkg::pclm_flags_t flags_reg;
	pclm_pkg::pclm_flags_t flags_next;
	logic [31:0] meters_reg;
	logic [31:0] meters_next;

	// a held counter reset keeps the count and both count flags cleared; pulses during it are dropped
	always_comb begin
		cnt_next = cnt_reg;
		flags_next = flags_reg;
		if (cnt_clr) begin
			cnt_next = 16'h0000;
			flags_next.designated_count_reached = 1'b0;
			flags_next.set_count_reached = 1'b0;
		end else begin
			if (cnt_pulse && cnt_reg < cfg_reg.final_count_target) begin
				cnt_next = cnt_reg + 16'h0001;
			end
			if (cnt_reg >= cfg_reg.designated_count_target) begin
				flags_next.designated_count_reached = 1'b1;
			end
			if (cnt_reg >= cfg_reg.final_count_target) begin
				flags_next.set_count_reached = 1'b1;
			end
		end
		if (len_clr) begin
			flags_next.length_reached = 1'b0;
		end else if (meters_reg > {16'h0000, cfg_reg.length_target}) begin
			flags_next.length_reached = 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// length meter
	// ----------------------------------------------------------------
	// converts by repeated subtraction, one meter per clock, so a very small
	// pulses-per-meter setting lets the reading trail a fast pulse train briefly
	logic [31:0] rem_reg;
	logic [31:0] rem_next;
	logic [31:0] len_pulses_reg;
	logic [31:0] len_pulses_next;
	logic [31:0] ppm_eff;

	always_comb begin
		ppm_eff = {16'h0000, cfg_reg.pulses_per_meter};
		if (cfg_reg.pulses_per_meter == 16'h0000) begin
			ppm_eff = 32'h00000001;
		end
		meters_next = meters_reg;
		rem_next = rem_reg;
		len_pulses_next = len_pulses_reg;
		if (len_clr) begin
			meters_next = 32'h00000000;
			rem_next = 32'h00000000;
			len_pulses_next = 32'h00000000;
		end else begin
			if (rem_reg >= ppm_eff) begin
				rem_next = rem_reg - ppm_eff;
				meters_next = meters_reg + 32'h00000001;
			end
			if (len_pulse) begin
				rem_next = rem_next + pclm_pkg::LEN_SCALE;
				len_pulses_next = len_pulses_reg + 32'h00000001;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_reg <= 16'h0000;
			flags_reg <= '0;
			meters_reg <= 32'h00000000;
			rem_reg <= 32'h00000000;
			len_pulses_reg <= 32'h00000000;
		end else begin
			cnt_reg <= cnt_next;
			flags_reg <= flags_next;
			meters_reg <= meters_next;
			rem_reg <= rem_next;
			len_pulses_reg <= len_pulses_next;
		end
	end

	// ----------------------------------------------------------------
	// output terminals
	// ----------------------------------------------------------------
	function automatic logic out_func(input logic [7:0] sel, input pclm_pkg::pclm_flags_t f);
		logic r;
		r = 1'b0;
		if (sel == pclm_pkg::FN_DESIG_COUNT_REACHED) r = f.designated_count_reached;
		if (sel == pclm_pkg::FN_SET_COUNT_REACHED) r = f.set_count_reached;
		if (sel == pclm_pkg::FN_LENGTH_REACHED) r = f.length_reached;
		return r;
	endfunction

	logic out_one_next;
	logic out_two_next;

	always_comb begin
		out_one_next = out_func(cfg_reg.output_one_function_select, flags_reg);
		out_two_next = out_func(cfg_reg.output_two_function_select, flags_reg);
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			digital_output_one <= 1'b0;
			digital_output_two <= 1'b0;
		end else begin
			digital_output_one <= out_one_next;
			digital_output_two <= out_two_next;
		end
	end

	// ----------------------------------------------------------------
	// wishbone slave
	// ----------------------------------------------------------------
	function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) r[i*8 +: 8] = nw[i*8 +: 8];
		end
		return r;
	endfunction

	logic [7:0] adr;
	logic req;
	logic wr;
	logic ack_next;
	logic [31:0] rd_next;
	logic [31:0] w;

	assign adr = {wb_adr_i[7:2], 2'b00};
	assign req = wb_cyc_i & wb_stb_i;
	// a write lands on the edge at which the master sees ack
	assign wr = req & wb_we_i & wb_ack_o;

	always_comb begin
		cfg_next = cfg_reg;
		ack_next = req & ~wb_ack_o;
		rd_next = 32'h00000000;
		w = 32'h00000000;
		unique case (adr)
			pclm_pkg::OFF_FINAL_COUNT: w = {16'h0000, cfg_reg.final_count_target};
			pclm_pkg::OFF_DESIG_COUNT: w = {16'h0000, cfg_reg.designated_count_target};
			pclm_pkg::OFF_LENGTH_TARGET: w = {16'h0000, cfg_reg.length_target};
			pclm_pkg::OFF_PULSES_PER_METER: w = {16'h0000, cfg_reg.pulses_per_meter};
			pclm_pkg::OFF_INPUT_SELECT: w = {8'h00, cfg_reg.fast_input_function_select,
				cfg_reg.input_two_function_select, cfg_reg.input_one_function_select};
			pclm_pkg::OFF_OUTPUT_SELECT: w = {16'h0000, cfg_reg.output_two_function_select,
				cfg_reg.output_one_function_select};
			pclm_pkg::OFF_CONTROL: w = {31'h00000000, cfg_reg.fixed_length_run};
			pclm_pkg::OFF_PULSE_COUNT: w = {16'h0000, cnt_reg};
			pclm_pkg::OFF_LENGTH_PULSES: w = len_pulses_reg;
			pclm_pkg::OFF_MEASURED_LENGTH: w = meters_reg;
			pclm_pkg::OFF_STATUS: w = {29'h00000000, flags_reg};
			default: w = 32'h00000000;
		endcase
		if (req & ~wb_we_i & ~wb_ack_o) begin
			rd_next = w;
		end
		if (wr) begin
			w = be_merge(w, wb_dat_i, wb_sel_i);
			unique case (adr)
				pclm_pkg::OFF_FINAL_COUNT: cfg_next.final_count_target = w[15:0];
				pclm_pkg::OFF_DESIG_COUNT: cfg_next.designated_count_target = w[15:0];
				pclm_pkg::OFF_LENGTH_TARGET: cfg_next.length_target = w[15:0];
				pclm_pkg::OFF_PULSES_PER_METER: cfg_next.pulses_per_meter = w[15:0];
				pclm_pkg::OFF_INPUT_SELECT: begin
					cfg_next.input_one_function_select = w[7:0];
					cfg_next.input_two_function_select = w[15:8];
					cfg_next.fast_input_function_select = w[23:16];
				end
				pclm_pkg::OFF_OUTPUT_SELECT: begin
					cfg_next.output_one_function_select = w[7:0];
					cfg_next.output_two_function_select = w[15:8];
				end
				pclm_pkg::OFF_CONTROL: cfg_next.fixed_length_run = w[0];
				default: cfg_next = cfg_reg;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			cfg_reg.final_count_target <= pclm_pkg::RST_FINAL_COUNT;
			cfg_reg.designated_count_target <= pclm_pkg::RST_DESIG_COUNT;
			cfg_reg.length_target <= pclm_pkg::RST_LENGTH_TARGET;
			cfg_reg.pulses_per_meter <= pclm_pkg::RST_PULSES_PER_METER;
			cfg_reg.fast_input_function_select <= pclm_pkg::RST_FUNC;
			cfg_reg.input_two_function_select <= pclm_pkg::RST_FUNC;
			cfg_reg.input_one_function_select <= pclm_pkg::RST_FUNC;
			cfg_reg.output_two_function_select <= pclm_pkg::RST_FUNC;
			cfg_reg.output_one_function_select <= pclm_pkg::RST_FUNC;
			cfg_reg.fixed_length_run <= 1'b0;
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			cfg_reg <= cfg_next;
			wb_ack_o <= ack_next;
			wb_dat_o <= rd_next;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	cnt_step_a: assert property ((cnt_pulse && !cnt_clr && cnt_reg < cfg_reg.final_count_target)
		|=> cnt_reg == $past(cnt_reg) + 16'h0001) else $error("count did not step on a pulse");
	cnt_stop_a: assert property ((!cnt_clr && cnt_reg >= cfg_reg.final_count_target)
		|=> $stable(cnt_reg) && flags_reg.set_count_reached) else $error("count ran past final target");
	desig_hold_a: assert property ((!cnt_clr && cnt_reg >= cfg_reg.designated_count_target)
		|=> flags_reg.designated_count_reached [*2] or cnt_clr) else $error("designated flag not held");
	cnt_clear_a: assert property (cnt_clr |=> cnt_reg == 16'h0000 && !flags_reg.set_count_reached
		&& !flags_reg.designated_count_reached) else $error("counter reset did not clear");
	len_count_a: assert property ((len_pulse && !len_clr)
		|=> len_pulses_reg == $past(len_pulses_reg) + 32'h00000001) else $error("length pulse lost");
	len_conv_a: assert property ((!len_clr && rem_reg >= ppm_eff)
		|=> meters_reg == $past(meters_reg) + 32'h00000001) else $error("meter conversion stalled");
	len_reach_a: assert property ((!len_clr && meters_reg > {16'h0000, cfg_reg.length_target})
		|=> flags_reg.length_reached) else $error("length reached not raised");
	len_clear_a: assert property (len_clr |=> meters_reg == 32'h00000000
		&& !flags_reg.length_reached) else $error("length reset did not clear");
	out_drive_a: assert property ((cfg_reg.output_two_function_select == pclm_pkg::FN_SET_COUNT_REACHED
		&& flags_reg.set_count_reached) |=> digital_output_two) else $error("output two not driven");
	wb_ack_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
endmodule

// ---- src/pclm_pkg.sv ----
// package for the pulse count and length monitor: register map, reset values,
// terminal function codes and the configuration carrier.
// assumes a 32-bit classic wishbone bus with byte addresses on wb_adr_i.
package pclm_pkg;

	// ----------------------------------------------------------------
	// register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFF_FINAL_COUNT = 8'h00;
	localparam logic [7:0] OFF_DESIG_COUNT = 8'h04;
	localparam logic [7:0] OFF_LENGTH_TARGET = 8'h08;
	localparam logic [7:0] OFF_PULSES_PER_METER = 8'h0C;
	localparam logic [7:0] OFF_INPUT_SELECT = 8'h10;
	localparam logic [7:0] OFF_OUTPUT_SELECT = 8'h14;
	localparam logic [7:0] OFF_CONTROL = 8'h18;
	localparam logic [7:0] OFF_PULSE_COUNT = 8'h1C;
	localparam logic [7:0] OFF_LENGTH_PULSES = 8'h20;
	localparam logic [7:0] OFF_MEASURED_LENGTH = 8'h24;
	localparam logic [7:0] OFF_STATUS = 8'h28;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] RST_FINAL_COUNT = 16'h03E8;
	localparam logic [15:0] RST_DESIG_COUNT = 16'h03E8;
	localparam logic [15:0] RST_LENGTH_TARGET = 16'h03E8;
	// pulses per meter in tenths: 100.0
	localparam logic [15:0] RST_PULSES_PER_METER = 16'h03E8;
	localparam logic [7:0] RST_FUNC = 8'h00;

	// each length pulse is worth ten tenths in the meter converter
	localparam logic [31:0] LEN_SCALE = 32'h0000000A;

	// ----------------------------------------------------------------
	// terminal function codes
	// ----------------------------------------------------------------
	localparam logic [7:0] FN_SET_COUNT_REACHED = 8'h14;
	localparam logic [7:0] FN_DESIG_COUNT_REACHED = 8'h15;
	localparam logic [7:0] FN_LENGTH_REACHED = 8'h16;
	localparam logic [7:0] FN_COUNTER_INPUT = 8'h2A;
	localparam logic [7:0] FN_COUNTER_RESET = 8'h2B;
	localparam logic [7:0] FN_LENGTH_COUNT_INPUT = 8'h2C;
	localparam logic [7:0] FN_LENGTH_RESET = 8'h2D;

	// input terminal index: one, two, fast pulse
	localparam int NUM_INPUTS = 3;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [15:0] final_count_target;
		logic [15:0] designated_count_target;
		logic [15:0] length_target;
		logic [15:0] pulses_per_meter;
		logic [7:0] fast_input_function_select;
		logic [7:0] input_two_function_select;
		logic [7:0] input_one_function_select;
		logic [7:0] output_two_function_select;
		logic [7:0] output_one_function_select;
		logic fixed_length_run;
	} pclm_cfg_t;

	typedef struct packed {
		logic length_reached;
		logic set_count_reached;
		logic designated_count_reached;
	} pclm_flags_t;

endpackage

// ---- src/pclm_term_sync.sv ----
// one digital input terminal: two-flop synchroniser plus rising-edge detect.
// assumes pin is asynchronous to clk and stays high or low for two clocks at least.
`timescale 1ns/1ps
module pclm_term_sync (
	input wire logic clk, // system clock
	input wire logic rst, // synchronous reset, active high
	input wire logic pin, // raw terminal level
	output logic level, // synchronised level
	output logic rise // one-cycle pulse on a rising edge
);
	logic [2:0] sync_reg;
	logic [2:0] sync_next;

	always_comb begin
		sync_next = {sync_reg[1:0], pin};
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			sync_reg <= 3'h0;
		end else begin
			sync_reg <= sync_next;
		end
	end

	// the first stage is read by nothing but the second
	assign level = sync_reg[1];
	assign rise = sync_reg[1] & ~sync_reg[2];
endmodule

// ---- test/pclm_pulse_src.sv ----
// model of the external pulse source wired to the three input terminals.
// assumes the bench clock; pins change only just after a rising edge, and idle low.
`timescale 1ns/1ps
module pclm_pulse_src (
	input wire logic clk, // system clock
	output logic [2:0] pin // terminals: [0] one, [1] two, [2] fast pulse
);
	initial begin
		pin = 3'h0;
	end

	// ----------------------------------------------------------------
	// pulse trains and levels
	// ----------------------------------------------------------------
	// width below 2 would be lost in the synchroniser, so callers keep it at 2 or more;
	// high-rate trains go on index 2, the fast pulse terminal
	task automatic send(input int idx, input int n, input int width);
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			pin[idx] <= 1'b1;
			repeat (width) @(posedge clk);
			pin[idx] <= 1'b0;
			repeat (width) @(posedge clk);
		end
	endtask

	task automatic hold(input int idx, input logic lvl);
		@(posedge clk);
		pin[idx] <= lvl;
	endtask
endmodule

// ---- test/pclm_tb_top.sv ----
// self-checking bench for the pulse count and length monitor.
// assumes the design acks every wishbone access one cycle after it is taken.
`timescale 1ns/1ps
module pclm_tb_top;
	typedef struct packed {
		logic we;
		logic [3:0] sel;
		logic [7:0] adr;
		logic [31:0] dat;
	} pclm_row_t;

	logic clk = 1'b0;
	logic rst = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h00000000;
	logic [31:0] wb_dat_o;
	logic wb_ack_o;
	logic [2:0] pin;
	logic [1:0] outs;
	logic [31:0] q;
	int n_errors = 0;
	int checks_done = 0;

	// reset reads, then writes with read-back; reads carry the expected value
	pclm_row_t rows [0:25] = '{
		'{1'b0, 4'hF, 8'h00, 32'h000003E8}, '{1'b0, 4'hF, 8'h04, 32'h000003E8},
		'{1'b0, 4'hF, 8'h08, 32'h000003E8}, '{1'b0, 4'hF, 8'h0C, 32'h000003E8},
		'{1'b0, 4'hF, 8'h10, 32'h00000000}, '{1'b0, 4'hF, 8'h14, 32'h00000000},
		'{1'b0, 4'hF, 8'h18, 32'h00000000}, '{1'b0, 4'hF, 8'h1C, 32'h00000000},
		'{1'b0, 4'hF, 8'h20, 32'h00000000}, '{1'b0, 4'hF, 8'h24, 32'h00000000},
		'{1'b0, 4'hF, 8'h28, 32'h00000000}, '{1'b0, 4'hF, 8'h2C, 32'h00000000},
		'{1'b1, 4'hF, 8'h00, 32'hABCD0007}, '{1'b0, 4'hF, 8'h00, 32'h00000007},
		'{1'b1, 4'hF, 8'h04, 32'h00000003}, '{1'b0, 4'hF, 8'h04, 32'h00000003},
		'{1'b1, 4'h2, 8'h08, 32'h00001200}, '{1'b0, 4'hF, 8'h08, 32'h000012E8},
		'{1'b1, 4'hF, 8'h10, 32'hFF002B2A}, '{1'b0, 4'hF, 8'h10, 32'h00002B2A},
		'{1'b1, 4'hF, 8'h14, 32'h00001415}, '{1'b0, 4'hF, 8'h14, 32'h00001415},
		'{1'b1, 4'hF, 8'h1C, 32'h00000005}, '{1'b0, 4'hF, 8'h1C, 32'h00000000},
		'{1'b1, 4'hF, 8'h2C, 32'h00000009}, '{1'b0, 4'hF, 8'h2C, 32'h00000000}
	};

	always #25 clk = ~clk;

	pclm_top uut (
		.clk(clk),
		.rst(rst),
		.wb_cyc_i(wb_cyc),
		.wb_stb_i(wb_stb),
		.wb_we_i(wb_we),
		.wb_adr_i(wb_adr),
		.wb_sel_i(wb_sel),
		.wb_dat_i(wb_dat),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.digital_input_one(pin[0]),
		.digital_input_two(pin[1]),
		.fast_pulse_input(pin[2]),
		.digital_output_one(outs[0]),
		.digital_output_two(outs[1])
	);

	pclm_pulse_src src (
		.clk(clk),
		.pin(pin)
	);

	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic stop_test();
		$display("checks_done=%0d n_errors=%0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_pin(input logic got, input logic exp);
		check32({31'h0, got}, {31'h0, exp});
	endtask

	// one classic cycle; entered just after a rising edge, ends one idle cycle later
	task automatic wb(input logic we, input logic [3:0] sel, input logic [7:0] adr, input logic [31:0] d,
		output logic [31:0] rd);
		int k;
		k = 0;
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_sel <= sel;
		wb_adr <= adr;
		wb_dat <= d;
		do begin
			@(posedge clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 10);
		rd = wb_dat_o;
		if (k >= 10) begin
			n_errors++;
			stop_test();
		end
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		wb_we <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		wb(1'b1, 4'hF, adr, d, q);
	endtask

	task automatic rd_chk(input logic [7:0] adr, input logic [31:0] exp);
		wb(1'b0, 4'hF, adr, 32'h0, q);
		check32(q, exp);
	endtask

	// terminal path is a few clocks long, so poll the output under a bound
	task automatic wait_out(input int o, input logic exp);
		for (int k = 0; k < 20 && outs[o] !== exp; k++) @(posedge clk);
		check_pin(outs[o], exp);
		if (outs[o] !== exp) stop_test();
	endtask

	task automatic settle();
		repeat (8) @(posedge clk);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check_pin(outs[0], 1'b0);
		check_pin(outs[1], 1'b0);
		foreach (rows[i]) begin
			wb(rows[i].we, rows[i].sel, rows[i].adr, rows[i].dat, q);
			if (!rows[i].we) check32(q, rows[i].dat);
		end
		// counting: designated 3, final 7, out one designated, out two final
		src.send(0, 2, 2);
		settle();
		check_pin(outs[0], 1'b0);
		src.send(0, 1, 2);
		wait_out(0, 1'b1);
		src.send(0, 3, 5);
		rd_chk(8'h1C, 32'h00000006);
		check_pin(outs[1], 1'b0);
		src.send(0, 1, 2);
		wait_out(1, 1'b1);
		src.send(0, 2, 2);
		settle();
		rd_chk(8'h1C, 32'h00000007);
		rd_chk(8'h28, 32'h00000003);
		check_pin(outs[0], 1'b1);
		// a pulse during counter reset must be dropped
		src.hold(1, 1'b1);
		src.send(0, 1, 2);
		wait_out(0, 1'b0);
		wait_out(1, 1'b0);
		rd_chk(8'h1C, 32'h00000000);
		src.hold(1, 1'b0);
		src.send(0, 3, 2);
		wait_out(0, 1'b1);
		rd_chk(8'h20, 32'h00000000);
		// length: 2.0 pulses per meter, target 2 m, fast terminal counts length
		wr(8'h0C, 32'h00000014);
		wr(8'h08, 32'h00000002);
		wr(8'h10, 32'h002C2B2D);
		wr(8'h14, 32'h00001516);
		src.send(2, 4, 2);
		settle();
		rd_chk(8'h20, 32'h00000004);
		rd_chk(8'h24, 32'h00000002);
		check_pin(outs[0], 1'b0);
		src.send(2, 2, 2);
		wait_out(0, 1'b1);
		settle();
		rd_chk(8'h24, 32'h00000003);
		rd_chk(8'h1C, 32'h00000003);
		src.hold(0, 1'b1);
		settle();
		rd_chk(8'h20, 32'h00000006);
		src.hold(0, 1'b0);
		wr(8'h18, 32'h00000001);
		src.hold(0, 1'b1);
		wait_out(0, 1'b0);
		rd_chk(8'h20, 32'h00000000);
		rd_chk(8'h24, 32'h00000000);
		src.hold(0, 1'b0);
		src.send(2, 6, 2);
		wait_out(0, 1'b1);
		// mid-run reset returns outputs, counts and settings to their reset values
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		check_pin(outs[0], 1'b0);
		check_pin(outs[1], 1'b0);
		rd_chk(8'h00, 32'h000003E8);
		rd_chk(8'h1C, 32'h00000000);
		rd_chk(8'h20, 32'h00000000);
		rd_chk(8'h24, 32'h00000000);
		stop_test();
	end
endmodule
